//--- hdl/scbs_pkg.sv
// Shared constants, pin bundles and state types of the serial bitstream source
// Notes on behaviour
// - Reset/enable low clears the address counter and floats the data output.
// - Chip select high after the reset pulse halts the counter and floats data.
// - Chip select low with reset/enable high lets the counter run and drives data.
// - Reset/enable low beats chip select: counter clears, data floats regardless.
// - Rising reset/enable latches operating mode and target protocol for the stream.
// - After the last bit and cascade assertion, the data output floats.
// - The restart instruction from the test port pulls the restart line low.
// - After its low phase the restart line is driven high to start configuration.
// - Leaving the asserting test-port state releases the restart line.
// - Reset/enable is open drain: each party only pulls low or releases.
// - Stored bits are read in sequence and shifted out on the bit clock: the oscillator in a first member, the incoming clock in a later one.
// - Reset/enable and chip select gate data buffer, counter and oscillator.
// - Only cascade-capable variants hand off through the cascade output.
// - Each bit clock rise advances and presents the next bit while enabled.
// - Cascade output goes low on the bit clock rise after the counter reaches its last address.
// - Select low at reset end makes a first member sourcing the bit clock.
package scbs_pkg;

  // Core clock
  localparam int CLOCK_MHZ = 25;

  // Oscillator bit period and its half period in core cycles, rounded down
  localparam int BIT_PERIOD_NS = 400;
  localparam int BIT_HALF_RAW = (BIT_PERIOD_NS / 2) * CLOCK_MHZ / 1000;
  localparam int BIT_HALF_CYCLES = (BIT_HALF_RAW < 1) ? 1 : BIT_HALF_RAW;

  // Least low time of the restart line, rounded up to core cycles
  localparam int RESTART_LOW_NS = 2000;
  localparam int RESTART_LOW_RAW = (RESTART_LOW_NS * CLOCK_MHZ + 999) / 1000;
  localparam int RESTART_LOW_CYCLES = (RESTART_LOW_RAW < 1) ? 1 : RESTART_LOW_RAW;

  // Default array depth and edge pointer width
  localparam int DEPTH_DEFAULT = 1024;
  localparam int EDGE_W_DEFAULT = 4;

  // Reset values of pin drivers
  localparam logic PIN_VALUE_RESET = 1'b0;
  localparam logic PIN_OE_RESET = 1'b0;
  localparam logic CASCADE_RESET = 1'b1;

  // Target family protocol latched at the reset/enable rise
  typedef enum logic [1:0] {
    PROTO_FAMILY_A,
    PROTO_FAMILY_B,
    PROTO_FAMILY_C,
    PROTO_FAMILY_D
  } scbs_proto_t;

  // Restart line sequencer
  typedef enum logic [1:0] {
    RS_IDLE,
    RS_LOW,
    RS_HIGH
  } scbs_restart_t;

  // A pin driver: level and output enable
  typedef struct packed {
    logic value;
    logic oe;
  } scbs_pin_t;

  // Memory load request
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic data;
  } scbs_load_t;

endpackage

//--- hdl/scbs_sync2.sv
// Two-flop level synchroniser, one bit per lane
module scbs_sync2 #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic clock,
  input wire logic reset,
  // Levels in and out
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut
);

  logic [WIDTH-1:0] stage1;

  // First stage is read only by the second
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1 <= '0;
      dataOut <= '0;
    end else begin
      stage1 <= dataIn;
      dataOut <= stage1;
    end
  end

endmodule

//--- hdl/scbs_edge_count.sv
// Counts rising edges of the incoming bit clock as a gray pointer
module scbs_edge_count #(
  parameter int WIDTH = 4
) (
  // Link clock and reset from the core domain
  input wire logic linkClock,
  input wire logic coreReset,
  // Gray-coded edge count
  output logic [WIDTH-1:0] grayCount
);

  logic [1:0] resetSync;
  logic [WIDTH-1:0] binCount;
  logic [WIDTH-1:0] next_bin;

  assign next_bin = binCount + WIDTH'(1);

  // Reset level brought into the link domain
  always_ff @(posedge linkClock) begin
    resetSync <= {resetSync[0], coreReset};
  end

  // One gray step per link edge, so any sample is a valid count
  always_ff @(posedge linkClock) begin
    if (resetSync[1]) begin
      binCount <= '0;
      grayCount <= '0;
    end else begin
      binCount <= next_bin;
      grayCount <= next_bin ^ (next_bin >> 1);
    end
  end

endmodule

//--- hdl/scbs_top.sv
// Serial configuration bitstream source: counter, pins, oscillator, cascade, restart
module scbs_top #(
  parameter int DEPTH = scbs_pkg::DEPTH_DEFAULT,
  parameter int ADDR_W = $clog2(DEPTH),
  parameter int EDGE_W = scbs_pkg::EDGE_W_DEFAULT,
  parameter bit CASCADE_EN = 1'b1,
  parameter int BIT_HALF = scbs_pkg::BIT_HALF_CYCLES,
  parameter int RESTART_LOW = scbs_pkg::RESTART_LOW_CYCLES
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic reset,
  // Incoming bit clock of a later chain member
  input wire logic serialBitClockIn,
  // Reset/enable open-drain line
  input wire logic resetEnableIn,
  output logic resetEnableOut,
  output logic resetEnableOe,
  // Chain select, active low
  input wire logic chainSelectN,
  // Target family strap
  input wire logic [1:0] protocolSelect,
  // Test port restart state, high while asserting
  input wire logic restartActive,
  // Array load port
  input wire scbs_pkg::scbs_load_t load,
  // Serial data toward the target
  output scbs_pkg::scbs_pin_t targetSerialInput,
  // Bit clock driven by a first member
  output scbs_pkg::scbs_pin_t serialBitClock,
  // Cascade output, active low
  output logic cascadeOutN,
  // Restart request toward the target
  output scbs_pkg::scbs_pin_t restartRequestN,
  // Latched mode
  output scbs_pkg::scbs_proto_t protocolMode,
  output logic firstMember,
  output logic streamDone
);

  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
  localparam int DIV_W = $clog2(BIT_HALF + 1);
  localparam int RST_W = $clog2(RESTART_LOW + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_HALF - 1);
  localparam logic [RST_W-1:0] RST_LAST = RST_W'(RESTART_LOW - 1);

  // Parameter checks
  if (DEPTH < 2) begin : g_bad_depth
    $error("DEPTH must be at least 2");
  end
  if ((1 << ADDR_W) < DEPTH) begin : g_bad_addr
    $error("ADDR_W too narrow for DEPTH");
  end
  if (EDGE_W < 2) begin : g_bad_edge
    $error("EDGE_W must be at least 2");
  end
  if (BIT_HALF < 1 || RESTART_LOW < 1) begin : g_bad_time
    $error("Timing counts must be at least 1");
  end

  // Stored bitstream
  logic memory [DEPTH];

  // Synchronised pin levels
  logic [4:0] pinRaw;
  logic [4:0] pinSync;
  logic enableLevel;
  logic selectNLevel;
  logic restartLevel;
  logic [1:0] protoLevel;

  // Mode and stream state
  logic enablePrev;
  logic enableRise;
  logic isFirst;
  logic [ADDR_W-1:0] address;
  logic finished;
  logic active;
  logic step;

  // Oscillator
  logic oscRun;
  logic [DIV_W-1:0] divCount;
  logic bitClock;
  logic oscRise;

  // Incoming edge tracking
  logic [EDGE_W-1:0] edgeGray;
  logic [EDGE_W-1:0] edgeGraySync;
  logic [EDGE_W-1:0] edgeBin;
  logic [EDGE_W-1:0] edgeSeen;
  logic edgePending;

  // Restart sequencer
  scbs_pkg::scbs_restart_t restartState;
  logic [RST_W-1:0] restartCount;

  // Next values
  logic [ADDR_W-1:0] next_address;
  logic next_finished;

  // Pins from outside pass two flops
  assign pinRaw = {protocolSelect, restartActive, chainSelectN, resetEnableIn};

  scbs_sync2 #(
    .WIDTH(5)
  ) u_pin_sync (
    .clock(clock),
    .reset(reset),
    .dataIn(pinRaw),
    .dataOut(pinSync)
  );

  assign enableLevel = pinSync[0];
  assign selectNLevel = pinSync[1];
  assign restartLevel = pinSync[2];
  assign protoLevel = pinSync[4:3];

  // Edge counter in the link domain
  scbs_edge_count #(
    .WIDTH(EDGE_W)
  ) u_edge_count (
    .linkClock(serialBitClockIn),
    .coreReset(reset),
    .grayCount(edgeGray)
  );

  // Gray pointer crosses into the core domain
  scbs_sync2 #(
    .WIDTH(EDGE_W)
  ) u_edge_sync (
    .clock(clock),
    .reset(reset),
    .dataIn(edgeGray),
    .dataOut(edgeGraySync)
  );

  // Gray to binary
  always_comb begin
    edgeBin[EDGE_W-1] = edgeGraySync[EDGE_W-1];
    for (int i = EDGE_W - 2; i >= 0; i--) begin
      edgeBin[i] = edgeBin[i+1] ^ edgeGraySync[i];
    end
  end

  // Array load, separate from the stream path
  always_ff @(posedge clock) begin
    if (load.valid && load.addr < 32'(DEPTH)) begin
      memory[load.addr[ADDR_W-1:0]] <= load.data;
    end
  end

  // Rise of the reset/enable line
  always_ff @(posedge clock) begin
    if (reset) begin
      enablePrev <= 1'b0;
    end else begin
      enablePrev <= enableLevel;
    end
  end

  assign enableRise = enableLevel & ~enablePrev;

  // Mode decided when reset/enable goes high
  always_ff @(posedge clock) begin
    if (reset) begin
      isFirst <= 1'b0;
      protocolMode <= scbs_pkg::PROTO_FAMILY_A;
    end else if (enableRise) begin
      isFirst <= ~selectNLevel;
      protocolMode <= scbs_pkg::scbs_proto_t'(protoLevel);
    end
  end

  // Enabled and selected; reset/enable wins over select
  assign active = enableLevel & ~selectNLevel;

  // Oscillator runs only for an enabled, selected first member
  assign oscRun = active & isFirst;

  always_ff @(posedge clock) begin
    if (reset || !oscRun) begin
      divCount <= '0;
      bitClock <= 1'b0;
    end else if (divCount == DIV_LAST) begin
      divCount <= '0;
      bitClock <= ~bitClock;
    end else begin
      divCount <= divCount + DIV_W'(1);
    end
  end

  // Bit clock about to rise this edge
  assign oscRise = oscRun & (divCount == DIV_LAST) & ~bitClock;

  // Later member: consume one incoming edge per core cycle
  assign edgePending = (edgeBin != edgeSeen);

  always_ff @(posedge clock) begin
    if (reset) begin
      edgeSeen <= '0;
    end else if (!active || isFirst) begin
      edgeSeen <= edgeBin; // Edges outside selection are dropped
    end else if (edgePending) begin
      edgeSeen <= edgeSeen + EDGE_W'(1);
    end
  end

  // One advance per bit clock rise, only while running
  assign step = active & ~finished & (isFirst ? oscRise : edgePending);

  // Address counter next state
  always_comb begin
    next_address = address;
    next_finished = finished;
    if (!enableLevel) begin
      next_address = '0;
      next_finished = 1'b0;
    end else if (step) begin
      if (address == LAST_ADDR) begin
        next_finished = 1'b1;
      end else begin
        next_address = address + ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      address <= '0;
      finished <= 1'b0;
    end else begin
      address <= next_address;
      finished <= next_finished;
    end
  end

  // Serial data pin: driven only while enabled, selected and not done
  always_ff @(posedge clock) begin
    if (reset) begin
      targetSerialInput.value <= scbs_pkg::PIN_VALUE_RESET;
      targetSerialInput.oe <= scbs_pkg::PIN_OE_RESET;
    end else begin
      targetSerialInput.value <= memory[next_address];
      targetSerialInput.oe <= active & ~next_finished;
    end
  end

  // Cascade output, only on cascade-capable builds
  always_ff @(posedge clock) begin
    if (reset) begin
      cascadeOutN <= scbs_pkg::CASCADE_RESET;
    end else begin
      cascadeOutN <= ~(CASCADE_EN & enableLevel & next_finished);
    end
  end

  // Bit clock pin: driven by a first member, low when stopped
  always_ff @(posedge clock) begin
    if (reset) begin
      serialBitClock.value <= scbs_pkg::PIN_VALUE_RESET;
      serialBitClock.oe <= scbs_pkg::PIN_OE_RESET;
    end else begin
      serialBitClock.value <= oscRun ? (bitClock ^ (divCount == DIV_LAST)) : 1'b0;
      serialBitClock.oe <= isFirst;
    end
  end

  // Reset/enable: only ever pulled low, here during own reset
  always_ff @(posedge clock) begin
    resetEnableOut <= 1'b0;
    resetEnableOe <= reset;
  end

  // Restart sequencer driven by the test-port state
  always_ff @(posedge clock) begin
    if (reset) begin
      restartState <= scbs_pkg::RS_IDLE;
      restartCount <= '0;
    end else begin
      case (restartState)
        scbs_pkg::RS_IDLE: begin
          restartCount <= '0;
          if (restartLevel) begin
            restartState <= scbs_pkg::RS_LOW;
          end
        end
        scbs_pkg::RS_LOW: begin
          if (!restartLevel) begin
            restartState <= scbs_pkg::RS_IDLE;
          end else if (restartCount == RST_LAST) begin
            restartState <= scbs_pkg::RS_HIGH;
          end else begin
            restartCount <= restartCount + RST_W'(1);
          end
        end
        scbs_pkg::RS_HIGH: begin
          if (!restartLevel) begin
            restartState <= scbs_pkg::RS_IDLE;
          end
        end
        default: begin
          restartState <= scbs_pkg::RS_IDLE;
        end
      endcase
    end
  end

  // Restart pin follows the sequencer state
  always_ff @(posedge clock) begin
    if (reset) begin
      restartRequestN.value <= scbs_pkg::PIN_VALUE_RESET;
      restartRequestN.oe <= scbs_pkg::PIN_OE_RESET;
    end else begin
      case (restartState)
        scbs_pkg::RS_LOW: begin
          restartRequestN.value <= 1'b0;
          restartRequestN.oe <= 1'b1;
        end
        scbs_pkg::RS_HIGH: begin
          restartRequestN.value <= 1'b1;
          restartRequestN.oe <= 1'b1;
        end
        default: begin
          restartRequestN.value <= 1'b0;
          restartRequestN.oe <= 1'b0;
        end
      endcase
    end
  end

  // Status mirrors
  always_ff @(posedge clock) begin
    if (reset) begin
      firstMember <= 1'b0;
      streamDone <= 1'b0;
    end else begin
      firstMember <= isFirst;
      streamDone <= next_finished;
    end
  end

endmodule

//--- sim/scbs_checker.sv
// Pin-level assertions on the bitstream source
module scbs_checker #(
  parameter int RESTART_LOW = 2
) (
  // Clocks and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic serialBitClockIn,
  // Watched pins
  input wire logic resetEnableIn,
  input wire logic resetEnableOut,
  input wire logic chainSelectN,
  input wire logic restartActive,
  input wire scbs_pkg::scbs_pin_t targetSerialInput,
  input wire scbs_pkg::scbs_pin_t serialBitClock,
  input wire logic cascadeOutN,
  input wire scbs_pkg::scbs_pin_t restartRequestN,
  input wire scbs_pkg::scbs_proto_t protocolMode,
  input wire logic firstMember,
  input wire logic streamDone
);
  logic [7:0] lowCount;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Length of the restart low phase
  always_ff @(posedge clock) begin
    if (reset || !(restartRequestN.oe && !restartRequestN.value)) begin
      lowCount <= 8'h00;
    end else begin
      lowCount <= lowCount + 8'h01;
    end
  end
  a_float_held_low: assert property ((!resetEnableIn)[*4] |-> !targetSerialInput.oe)
    else $error("data driven while reset/enable low");
  a_float_deselect: assert property (chainSelectN[*4] |-> !targetSerialInput.oe)
    else $error("data driven while deselected");
  a_drive_selected: assert property ((!chainSelectN && resetEnableIn && !streamDone)[*6]
    |-> targetSerialInput.oe) else $error("data not driven while selected");
  a_mode_stable: assert property (resetEnableIn[*6] |-> $stable(protocolMode))
    else $error("mode changed while enabled");
  a_float_at_end: assert property ($fell(cascadeOutN) |-> $fell(targetSerialInput.oe))
    else $error("data not released at cascade");
  a_restart_pull: assert property (restartActive[*6] |-> restartRequestN.oe)
    else $error("restart line not driven");
  a_restart_high: assert property ($rose(restartRequestN.value) && restartRequestN.oe
    |-> lowCount >= 8'(RESTART_LOW)) else $error("restart low phase too short");
  a_restart_release: assert property ((!restartActive)[*6] |-> !restartRequestN.oe)
    else $error("restart line not released");
  a_drain_only: assert property (resetEnableOut == 1'b0)
    else $error("reset/enable driven high");
  a_step_on_rise: assert property (firstMember && targetSerialInput.oe && $past(targetSerialInput.oe)
    && $changed(targetSerialInput.value) |-> $rose(serialBitClock.value)) else $error("bit changed off clock rise");
  a_clock_held: assert property ((!resetEnableIn)[*5] |-> !serialBitClock.value)
    else $error("bit clock runs in reset");
  a_clock_first: assert property ($rose(resetEnableIn) |-> ##4 (serialBitClock.oe == !$past(chainSelectN, 4)))
    else $error("bit clock drive mismatches chain role");
endmodule

bind scbs_top scbs_checker #(.RESTART_LOW(RESTART_LOW)) chk (.clock(clock), .reset(reset),
  .serialBitClockIn(serialBitClockIn), .resetEnableIn(resetEnableIn), .resetEnableOut(resetEnableOut),
  .chainSelectN(chainSelectN), .restartActive(restartActive), .targetSerialInput(targetSerialInput),
  .serialBitClock(serialBitClock), .cascadeOutN(cascadeOutN), .restartRequestN(restartRequestN),
  .protocolMode(protocolMode), .firstMember(firstMember), .streamDone(streamDone));

//--- sim/scbs_target_model.sv
// Behavioural target device taking the serial bitstream
module scbs_target_model (
  // Core clock
  input wire logic clock,
  // Pins seen by the target
  input wire logic bitClock,
  input wire logic dataLine,
  input wire logic dataOe,
  input wire logic enableLine,
  input wire scbs_pkg::scbs_pin_t restartPin,
  // Bench request to hold the target in reset
  input wire logic holdLow,
  // Pull-down on the reset/enable line
  output logic pullLowOe,
  // Captured stream
  output logic [7:0] captured,
  output logic [7:0] bitCount
);
  logic lastClock;
  logic lastData;
  logic lastOe;
  // Only pulls low, never drives high
  assign pullLowOe = holdLow || (restartPin.oe && !restartPin.value);
  // Take the bit that stood before each bit clock rise
  always @(posedge clock) begin
    lastClock <= bitClock;
    lastData <= dataLine;
    lastOe <= dataOe;
    if (!enableLine) begin
      bitCount <= 8'h00;
    end else if (bitClock && !lastClock && lastOe) begin
      captured <= {captured[6:0], lastData};
      bitCount <= bitCount + 8'h01;
    end
  end
endmodule

//--- sim/scbs_tb_top.sv
// Self-checking bench of the bitstream source
module scbs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 8;
  localparam int RESTART_LOW = 8;
  // Strap and select in, mode and pins out
  typedef struct packed {
    logic [1:0] strap;
    logic selN;
    logic [1:0] mode;
    logic first;
    logic oe;
  } scbs_row_t;
  localparam scbs_row_t ROWS [5] = '{'{2'h0, 1'b0, 2'h0, 1'b1, 1'b1}, '{2'h1, 1'b0, 2'h1, 1'b1, 1'b1},
    '{2'h2, 1'b0, 2'h2, 1'b1, 1'b1}, '{2'h3, 1'b0, 2'h3, 1'b1, 1'b1}, '{2'h2, 1'b1, 2'h2, 1'b0, 1'b0}};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic linkClock = 1'b0;
  logic chainSelectN = 1'b0;
  logic restartActive = 1'b0;
  logic holdLow = 1'b0;
  logic [1:0] protocolSelect = 2'h0;
  logic [7:0] pattern = 8'hB4;
  logic [7:0] expCap;
  logic [7:0] captured;
  logic [7:0] bitCount;
  scbs_pkg::scbs_load_t load = '0;
  scbs_pkg::scbs_pin_t dataPin;
  scbs_pkg::scbs_pin_t clockPin;
  scbs_pkg::scbs_pin_t restartPin;
  scbs_pkg::scbs_proto_t protocolMode;
  logic resetEnableOut;
  logic resetEnableOe;
  logic pullLowOe;
  logic cascadeOutN;
  logic firstMember;
  logic streamDone;
  logic cascadeNoChain;
  int failures = 0;
  int checked = 0;
  // Wire levels from all drivers, pull-up on the open-drain line
  wire enableLine = !(resetEnableOe || pullLowOe);
  wire bitClockLine = clockPin.oe ? clockPin.value : linkClock;
  wire dataLine = dataPin.oe ? dataPin.value : ~dataPin.value;
  always #20 clock = ~clock;
  scbs_top #(.DEPTH(DEPTH), .BIT_HALF(2), .RESTART_LOW(RESTART_LOW)) dut (.clock(clock), .reset(reset),
    .serialBitClockIn(bitClockLine), .resetEnableIn(enableLine), .resetEnableOut(resetEnableOut),
    .resetEnableOe(resetEnableOe), .chainSelectN(chainSelectN), .protocolSelect(protocolSelect),
    .restartActive(restartActive), .load(load), .targetSerialInput(dataPin), .serialBitClock(clockPin),
    .cascadeOutN(cascadeOutN), .restartRequestN(restartPin), .protocolMode(protocolMode),
    .firstMember(firstMember), .streamDone(streamDone));
  scbs_target_model target (.clock(clock), .bitClock(bitClockLine), .dataLine(dataLine), .dataOe(dataPin.oe),
    .enableLine(enableLine), .restartPin(restartPin), .holdLow(holdLow), .pullLowOe(pullLowOe),
    .captured(captured), .bitCount(bitCount));
  // Build without cascade support, fed the same pins
  scbs_top #(.DEPTH(DEPTH), .CASCADE_EN(1'b0), .BIT_HALF(2), .RESTART_LOW(RESTART_LOW)) noChain (.clock(clock),
    .reset(reset), .serialBitClockIn(bitClockLine), .resetEnableIn(enableLine), .resetEnableOut(), .resetEnableOe(),
    .chainSelectN(chainSelectN), .protocolSelect(protocolSelect), .restartActive(restartActive), .load(load),
    .targetSerialInput(), .serialBitClock(), .cascadeOutN(cascadeNoChain), .restartRequestN(), .protocolMode(),
    .firstMember(), .streamDone());
  // Comparisons and closing report
  task automatic checkBit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic checkVec(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Hold the line low, set strap and select, release
  task automatic startStream(input logic [1:0] strap, input logic selN);
    holdLow <= 1'b1;
    chainSelectN <= selN;
    protocolSelect <= strap;
    tick(6);
    holdLow <= 1'b0;
    tick(6);
  endtask
  task automatic waitDone;
    int n;
    n = 0;
    while (streamDone !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    if (n == 300) begin
      failures++;
      conclude();
    end
  endtask
  // Main sequence
  initial begin
    for (int i = 0; i < DEPTH; i++) expCap[DEPTH-1-i] = pattern[i];
    tick(1);
    // Link edges during reset so the link-side counter starts clean
    repeat (4) begin
      #6 linkClock = 1'b1;
      #6 linkClock = 1'b0;
    end
    tick(3);
    checkBit(resetEnableOe, 1'b1);
    reset <= 1'b0;
    tick(1);
    checkBit(cascadeOutN, 1'b1);
    checkBit(dataPin.oe, 1'b0);
    $display("reset test ended");
    for (int i = 0; i < DEPTH; i++) begin
      load <= {1'b1, 32'(i), pattern[i]};
      tick(1);
    end
    load <= '0;
    checkBit(resetEnableOe, 1'b0);
    foreach (ROWS[r]) begin
      startStream(ROWS[r].strap, ROWS[r].selN);
      protocolSelect <= ~ROWS[r].strap;
      tick(2);
      checkVec({6'h00, protocolMode}, {6'h00, ROWS[r].mode});
      checkBit(firstMember, ROWS[r].first);
      checkBit(clockPin.oe, ROWS[r].first);
      checkBit(dataPin.oe, ROWS[r].oe);
      $display("row %0d ended", r);
    end
    // Abort, restart from zero, deselect mid-stream
    startStream(2'h1, 1'b0);
    holdLow <= 1'b1;
    tick(5);
    checkBit(dataPin.oe, 1'b0);
    checkBit(clockPin.value, 1'b0);
    holdLow <= 1'b0;
    tick(8);
    chainSelectN <= 1'b1;
    tick(5);
    checkBit(dataPin.oe, 1'b0);
    chainSelectN <= 1'b0;
    waitDone();
    tick(2);
    checkVec(captured, expCap);
    checkVec(bitCount, 8'h08);
    checkBit(cascadeOutN, 1'b0);
    checkBit(cascadeNoChain, 1'b1);
    checkBit(dataPin.oe, 1'b0);
    $display("first member stream ended");
    // Later member clocked from the link
    startStream(2'h3, 1'b1);
    chainSelectN <= 1'b0;
    tick(6);
    checkBit(dataPin.oe, 1'b1);
    #7;
    repeat (DEPTH) begin
      #6 linkClock = 1'b1;
      #6 linkClock = 1'b0;
    end
    tick(30);
    checkBit(streamDone, 1'b1);
    checkBit(cascadeOutN, 1'b0);
    checkBit(dataPin.oe, 1'b0);
    $display("later member stream ended");
    // Restart request from the test port
    restartActive <= 1'b1;
    tick(7);
    checkBit(restartPin.oe, 1'b1);
    checkBit(restartPin.value, 1'b0);
    checkBit(enableLine, 1'b0);
    tick(RESTART_LOW + 2);
    checkBit(restartPin.value, 1'b1);
    restartActive <= 1'b0;
    tick(8);
    checkBit(restartPin.oe, 1'b0);
    $display("restart ended");
    conclude();
  end
endmodule
